//--- hdl/lane_alarm_pkg.sv
// Constants and types shared by the lane alarm latch bank
// How it works
// [RULE1] One latch pair per lane, sixteen at most
// [RULE2] A flag stays set after its condition ends
// [RULE3] Read returns the value then clears; writes ignored
// [RULE4] Word one bits 15:12 transmit bias flags
// [RULE5] Word one bits 11:8 transmit power flags
// [RULE6] Word one bits 7:4 laser temperature flags
// [RULE7] Word one bits 3:0 receive power flags
// [RULE8] Receive power threshold set chosen at B015h
// [RULE9] Word two bits 15:12 receive laser bias
// [RULE10] Word two bits 11:8 receive laser output
// [RULE11] Word two bits 7:4 receive laser temperature
// [RULE12] Word two bits 3:0 transmit modulator bias
// [RULE13] All latch words reset to zero
// [RULE14] Each latched bit follows its live status bit
// [RULE15] A set in the clearing cycle survives
package lane_alarm_pkg;

   // ***************************************************
   // Sizes
   // ***************************************************
   localparam int LANE_MAX = 16;            // Most lanes a module can have
   localparam int WORD_W = 16;              // Width of every register
   localparam int ADDR_W = 16;              // Width of the register address

   // ***************************************************
   // Register addresses
   // ***************************************************
   localparam logic [15:0] LATCH_ONE_BASE = 16'hb1b0;   // Lane 0 of latch word one
   localparam logic [15:0] LATCH_TWO_BASE = 16'hb1c0;   // Lane 0 of latch word two
   localparam logic [15:0] RX_THR_SEL_ADDR = 16'hb015;  // Receive power threshold select

   // ***************************************************
   // Field positions and reset values
   // ***************************************************
   localparam int GROUP_A_LSB = 12;         // Bias group (both words)
   localparam int GROUP_B_LSB = 8;          // Power or output group
   localparam int GROUP_C_LSB = 4;          // Temperature group
   localparam int GROUP_D_LSB = 0;          // Receive power or modulator group
   localparam int HIGH_ALARM_POS = 3;       // Within a four-flag group
   localparam int LOW_ALARM_POS = 0;        // Within a four-flag group
   localparam int RX_THR_SEL_POS = 0;       // Select bit inside its register
   localparam logic [15:0] LATCH_RESET = 16'h0000;    // Latch word reset value
   localparam logic RX_THR_SEL_RESET = 1'b0;          // Select register reset value
   localparam logic [15:0] UNMAPPED_READ = 16'h0000;  // Answer to a stray address

   // ***************************************************
   // Carriers
   // ***************************************************
   // Four flags of one monitored quantity
   typedef struct packed {
      logic high_alarm;
      logic high_warning;
      logic low_warning;
      logic low_alarm;
   } flag_group_t;

   // Layout of latch word one
   typedef struct packed {
      flag_group_t tx_bias;
      flag_group_t tx_power;
      flag_group_t laser_temp;
      flag_group_t rx_power;
   } latch_one_t;

   // Layout of latch word two
   typedef struct packed {
      flag_group_t rx_laser_bias;
      flag_group_t rx_laser_output;
      flag_group_t rx_laser_temp;
      flag_group_t tx_mod_bias;
   } latch_two_t;

endpackage

//--- hdl/alarm_flag_latch.sv
// One sixteen-flag latch word that sets on live flags and clears on read
`timescale 1ns/1ns
module alarm_flag_latch (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic [15:0] live_flags,
   input wire logic read_clear,
   output logic [15:0] latched
);

   // ***************************************************
   // Latch storage
   // ***************************************************
   logic [15:0] latch_reg;    // Held flags
   logic [15:0] latch_next;   // Next value of the held flags

   // Clear on read, but a live flag always wins
   always_comb begin
      if (read_clear) begin
         latch_next = live_flags;                        // RULE3 RULE15
      end else begin
         latch_next = latch_reg | live_flags;            // RULE2 RULE14
      end
   end

   // Flags update only while the clock enable is high
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         latch_reg <= lane_alarm_pkg::LATCH_RESET;       // RULE13
      end else if (clk_en) begin
         latch_reg <= latch_next;
      end
   end

   assign latched = latch_reg;

   // ***************************************************
   // Checks
   // ***************************************************
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   AST_LIVE_SETS: assert property ( // RULE14
      clk_en |=> ((latched & $past(live_flags)) == $past(live_flags)))
      else $error("live flag not latched");

   AST_HOLDS: assert property ( // RULE2
      (clk_en && !read_clear) ##1 (clk_en && !read_clear)
      |=> ((latched & $past(latched, 2)) == $past(latched, 2)))
      else $error("latched flag dropped without read");

   AST_READ_CLEARS: assert property ( // RULE3
      (clk_en && read_clear && live_flags == 16'h0000) |=> latched == 16'h0000)
      else $error("read did not clear word");

   AST_SET_WINS: assert property ( // RULE15
      (clk_en && read_clear) |=> latched == $past(live_flags))
      else $error("event lost during clear");

   AST_FROZEN: assert property (
      !clk_en |=> $stable(latched))
      else $error("latch moved while disabled");

   AST_RESET_ZERO: assert property ( // RULE13
      $fell(rst) |-> latched == lane_alarm_pkg::LATCH_RESET)
      else $error("latch not zero after reset");

endmodule

//--- hdl/lane_alarm_latch_bank.sv
// Bank of per-lane latched alarm and warning words behind a register port
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ns
module lane_alarm_latch_bank #(
   parameter int unsigned LANE_COUNT = 16
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire lane_alarm_pkg::latch_one_t [lane_alarm_pkg::LANE_MAX-1:0] live_one,
   input wire lane_alarm_pkg::flag_group_t [lane_alarm_pkg::LANE_MAX-1:0] rx_power_alt,
   input wire lane_alarm_pkg::latch_two_t [lane_alarm_pkg::LANE_MAX-1:0] live_two,
   output logic rx_thr_sel
);

   // ***************************************************
   // Address decoding
   // ***************************************************
   // True when the address names the given lane of a latch word
   function automatic logic lane_hit(input logic [15:0] addr, input logic [15:0] base,
                                     input int lane);
      logic [15:0] target;
      target = base + 16'(lane);
      lane_hit = (addr == target) && (lane < int'(LANE_COUNT));
   endfunction

   // True when the address falls in a latch word's lane range
   function automatic logic word_hit(input logic [15:0] addr, input logic [15:0] base);
      logic [15:0] span;
      span = addr - base;
      word_hit = (addr >= base) && (span < 16'(LANE_COUNT));
   endfunction

   // ***************************************************
   // Storage and wires
   // ***************************************************
   logic rx_thr_sel_reg;      // Chosen receive power threshold set
   logic [15:0] rdata_reg;    // Read data, valid the cycle after a read
   logic [15:0] rdata_next;   // Read data mux output
   logic [15:0] latch_one_q [lane_alarm_pkg::LANE_MAX];   // Word one per lane
   logic [15:0] latch_two_q [lane_alarm_pkg::LANE_MAX];   // Word two per lane
   logic [15:0] one_index;    // Lane offset into word one
   logic [15:0] two_index;    // Lane offset into word two

   assign one_index = reg_addr - lane_alarm_pkg::LATCH_ONE_BASE;
   assign two_index = reg_addr - lane_alarm_pkg::LATCH_TWO_BASE;

   // ***************************************************
   // Threshold select register
   // ***************************************************
   // Software write picks which receive power flag set is latched
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rx_thr_sel_reg <= lane_alarm_pkg::RX_THR_SEL_RESET;
      end else if (clk_en && reg_wr && reg_addr == lane_alarm_pkg::RX_THR_SEL_ADDR) begin
         rx_thr_sel_reg <= reg_wdata[lane_alarm_pkg::RX_THR_SEL_POS];   // RULE8
      end
   end

   assign rx_thr_sel = rx_thr_sel_reg;

   // ***************************************************
   // Per-lane latch words
   // ***************************************************
   // One pair of latch words for each lane the module uses
   for (genvar n = 0; n < lane_alarm_pkg::LANE_MAX; n++) begin : g_lane
      lane_alarm_pkg::latch_one_t one_live;   // Word one live flags after select
      logic one_clear;                        // Read of this lane's word one
      logic two_clear;                        // Read of this lane's word two

      // Build word one from live flags, receive power per select
      always_comb begin
         one_live.tx_bias = live_one[n].tx_bias;           // RULE4
         one_live.tx_power = live_one[n].tx_power;         // RULE5
         one_live.laser_temp = live_one[n].laser_temp;     // RULE6
         if (rx_thr_sel_reg) begin
            one_live.rx_power = rx_power_alt[n];           // RULE7 RULE8
         end else begin
            one_live.rx_power = live_one[n].rx_power;      // RULE7 RULE8
         end
      end

      // Reads clear; writes never reach the latch words
      assign one_clear = reg_rd && lane_hit(reg_addr, lane_alarm_pkg::LATCH_ONE_BASE, n); // RULE3
      assign two_clear = reg_rd && lane_hit(reg_addr, lane_alarm_pkg::LATCH_TWO_BASE, n); // RULE3

      if (n < LANE_COUNT) begin : g_used
         // Word one of this lane
         alarm_flag_latch u_one (
            .ref_clk(ref_clk),
            .rst(rst),
            .clk_en(clk_en),
            .live_flags(one_live),
            .read_clear(one_clear),
            .latched(latch_one_q[n])
         ); // RULE1

         // Word two of this lane, fields in place
         alarm_flag_latch u_two (
            .ref_clk(ref_clk),
            .rst(rst),
            .clk_en(clk_en),
            .live_flags(live_two[n]),
            .read_clear(two_clear),
            .latched(latch_two_q[n])
         ); // RULE1 RULE9 RULE10 RULE11 RULE12
      end else begin : g_absent
         // Lanes the module lacks read as reset value
         assign latch_one_q[n] = lane_alarm_pkg::LATCH_RESET;
         assign latch_two_q[n] = lane_alarm_pkg::LATCH_RESET;
      end
   end

   // ***************************************************
   // Read path
   // ***************************************************
   // Select the addressed word; stray addresses read zero
   always_comb begin
      rdata_next = lane_alarm_pkg::UNMAPPED_READ;
      if (word_hit(reg_addr, lane_alarm_pkg::LATCH_ONE_BASE)) begin
         rdata_next = latch_one_q[one_index[3:0]];             // RULE3
      end else if (word_hit(reg_addr, lane_alarm_pkg::LATCH_TWO_BASE)) begin
         rdata_next = latch_two_q[two_index[3:0]];             // RULE3
      end else if (reg_addr == lane_alarm_pkg::RX_THR_SEL_ADDR) begin
         rdata_next = 16'h0000;
         rdata_next[lane_alarm_pkg::RX_THR_SEL_POS] = rx_thr_sel_reg;
      end
   end

   // With the clock enable high, read data stands one cycle after the strobe, zero otherwise
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdata_reg <= 16'h0000;
      end else if (clk_en) begin
         if (reg_rd) begin
            rdata_reg <= rdata_next;
         end else begin
            rdata_reg <= 16'h0000;
         end
      end
   end

   assign reg_rdata = rdata_reg;

   // ***************************************************
   // Checks
   // ***************************************************
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   AST_LANE0_ONE_READ: assert property ( // RULE3
      (clk_en && reg_rd && reg_addr == lane_alarm_pkg::LATCH_ONE_BASE)
      |=> reg_rdata == $past(latch_one_q[0]))
      else $error("lane 0 word one read mismatch");

   AST_LAST_TWO_READ: assert property ( // RULE1
      (clk_en && reg_rd
       && reg_addr == lane_alarm_pkg::LATCH_TWO_BASE + 16'(LANE_COUNT - 1))
      |=> reg_rdata == $past(latch_two_q[LANE_COUNT-1]))
      else $error("last lane word two read mismatch");

   AST_WRITE_IGNORED: assert property ( // RULE3
      (clk_en && reg_wr && live_one[0] == 16'h0000 && rx_power_alt[0] == 4'h0)
      |=> latch_one_q[0] == $past(latch_one_q[0]))
      else $error("write changed a latch word");

   AST_TX_BIAS_HIGH: assert property ( // RULE4
      (clk_en && live_one[0].tx_bias.high_alarm)
      |=> latch_one_q[0][lane_alarm_pkg::GROUP_A_LSB + lane_alarm_pkg::HIGH_ALARM_POS])
      else $error("transmit bias alarm not in bit 15");

   AST_TX_POWER_LOW: assert property ( // RULE5
      (clk_en && live_one[0].tx_power.low_alarm)
      |=> latch_one_q[0][lane_alarm_pkg::GROUP_B_LSB + lane_alarm_pkg::LOW_ALARM_POS])
      else $error("transmit power alarm not in bit 8");

   AST_RX_SELECT: assert property ( // RULE8
      (clk_en && rx_thr_sel_reg && rx_power_alt[0].high_alarm)
      |=> latch_one_q[0][lane_alarm_pkg::GROUP_D_LSB + lane_alarm_pkg::HIGH_ALARM_POS])
      else $error("alternate receive power set ignored");

   AST_MOD_BIAS_LOW: assert property ( // RULE12
      (clk_en && live_two[0].tx_mod_bias.low_alarm)
      |=> latch_two_q[0][lane_alarm_pkg::GROUP_D_LSB + lane_alarm_pkg::LOW_ALARM_POS])
      else $error("modulator bias alarm not in bit 0");

   AST_READ_THEN_ZERO: assert property ( // RULE3
      (clk_en && reg_rd && reg_addr == lane_alarm_pkg::LATCH_TWO_BASE
       && live_two[0] == 16'h0000)
      |=> latch_two_q[0] == 16'h0000)
      else $error("read did not clear lane 0 word two");

   AST_UNMAPPED_ZERO: assert property (
      (clk_en && reg_rd && reg_addr == 16'h0000) |=> reg_rdata == 16'h0000)
      else $error("stray address read nonzero");

   AST_NO_READ_ZERO: assert property (
      (clk_en && !reg_rd) |=> reg_rdata == 16'h0000)
      else $error("read data outside read slot");

   // Transmit bias low alarm sits at the bottom of its group
   AST_TX_BIAS_LOW: assert property ( // RULE4
      (clk_en && live_one[0].tx_bias.low_alarm)
      |=> latch_one_q[0][lane_alarm_pkg::GROUP_A_LSB + lane_alarm_pkg::LOW_ALARM_POS])
      else $error("transmit bias low alarm not in bit 12");

   // Laser temperature low alarm lands in bit 4
   AST_LASER_TEMP_LOW: assert property ( // RULE6
      (clk_en && live_one[0].laser_temp.low_alarm)
      |=> latch_one_q[0][lane_alarm_pkg::GROUP_C_LSB + lane_alarm_pkg::LOW_ALARM_POS])
      else $error("laser temperature alarm not in bit 4");

   // Primary receive power flags latch while the select is clear
   AST_RX_POWER_LOW: assert property ( // RULE7
      (clk_en && !rx_thr_sel_reg && live_one[0].rx_power.low_alarm)
      |=> latch_one_q[0][lane_alarm_pkg::GROUP_D_LSB + lane_alarm_pkg::LOW_ALARM_POS])
      else $error("receive power alarm not in bit 0");

   // Primary receive power flags are ignored while the select is set
   AST_RX_PRIMARY_MASKED: assert property ( // RULE8
      (clk_en && rx_thr_sel_reg && rx_power_alt[0] == 4'h0 && !reg_rd)
      |=> 4'(latch_one_q[0] >> lane_alarm_pkg::GROUP_D_LSB)
          == 4'($past(latch_one_q[0]) >> lane_alarm_pkg::GROUP_D_LSB))
      else $error("primary receive power set latched under select");

   // Receive laser bias low alarm lands in bit 12
   AST_RX_BIAS_LOW: assert property ( // RULE9
      (clk_en && live_two[0].rx_laser_bias.low_alarm)
      |=> latch_two_q[0][lane_alarm_pkg::GROUP_A_LSB + lane_alarm_pkg::LOW_ALARM_POS])
      else $error("receive laser bias alarm not in bit 12");

   // Receive laser output low alarm lands in bit 8
   AST_RX_OUTPUT_LOW: assert property ( // RULE10
      (clk_en && live_two[0].rx_laser_output.low_alarm)
      |=> latch_two_q[0][lane_alarm_pkg::GROUP_B_LSB + lane_alarm_pkg::LOW_ALARM_POS])
      else $error("receive laser output alarm not in bit 8");

   // Receive laser temperature low alarm lands in bit 4
   AST_RX_TEMP_LOW: assert property ( // RULE11
      (clk_en && live_two[0].rx_laser_temp.low_alarm)
      |=> latch_two_q[0][lane_alarm_pkg::GROUP_C_LSB + lane_alarm_pkg::LOW_ALARM_POS])
      else $error("receive laser temperature alarm not in bit 4");

   // Lanes past the module's count read as unmapped
   AST_ABSENT_LANE: assert property ( // RULE1
      (int'(LANE_COUNT) < lane_alarm_pkg::LANE_MAX && clk_en && reg_rd
       && reg_addr == lane_alarm_pkg::LATCH_ONE_BASE + 16'(LANE_COUNT))
      |=> reg_rdata == lane_alarm_pkg::UNMAPPED_READ)
      else $error("absent lane read nonzero");

   // Last lane's words start empty after reset
   AST_RESET_LAST_LANE: assert property ( // RULE13
      $fell(rst) |-> (latch_one_q[LANE_COUNT-1] == lane_alarm_pkg::LATCH_RESET
                      && latch_two_q[LANE_COUNT-1] == lane_alarm_pkg::LATCH_RESET))
      else $error("last lane not zero after reset");

   // Select write takes the written bit
   AST_SEL_WRITE: assert property ( // RULE8
      (clk_en && reg_wr && reg_addr == lane_alarm_pkg::RX_THR_SEL_ADDR)
      |=> rx_thr_sel == 1'($past(reg_wdata) >> lane_alarm_pkg::RX_THR_SEL_POS))
      else $error("select write not taken");

   // Select holds unless written
   AST_SEL_HOLDS: assert property ( // RULE8
      !(clk_en && reg_wr && reg_addr == lane_alarm_pkg::RX_THR_SEL_ADDR)
      |=> $stable(rx_thr_sel))
      else $error("select changed without a write");

   // Select reads back in its own bit
   AST_SEL_READBACK: assert property ( // RULE8
      (clk_en && reg_rd && reg_addr == lane_alarm_pkg::RX_THR_SEL_ADDR)
      |=> reg_rdata[lane_alarm_pkg::RX_THR_SEL_POS] == $past(rx_thr_sel_reg))
      else $error("select read back wrong");

   // Writes leave a latched word alone
   AST_WRITE_KEEPS_WORD: assert property ( // RULE3
      (clk_en && reg_wr && !rx_thr_sel_reg && live_one[3] == 16'h0000)
      |=> latch_one_q[3] == $past(latch_one_q[3]))
      else $error("write disturbed lane 3 word one");

   // Read data freezes with the clock enable
   AST_RDATA_FROZEN: assert property (
      !clk_en |=> $stable(reg_rdata))
      else $error("read data moved while disabled");

   COV_CLEAR_LATCHED: cover property (
      (clk_en && reg_rd && reg_addr == lane_alarm_pkg::LATCH_ONE_BASE
       && latch_one_q[0] != 16'h0000));

   COV_SET_DURING_CLEAR: cover property (
      (clk_en && reg_rd && reg_addr == lane_alarm_pkg::LATCH_TWO_BASE + 16'h0001
       && live_two[1] != 16'h0000));

   COV_SELECT_FLIP: cover property (
      $rose(rx_thr_sel_reg));

   COV_HELD_AFTER_GONE: cover property (
      (clk_en && live_one[0].laser_temp.low_alarm)
      ##1 (clk_en && !live_one[0].laser_temp.low_alarm)
      ##1 latch_one_q[0][lane_alarm_pkg::GROUP_C_LSB + lane_alarm_pkg::LOW_ALARM_POS]);

endmodule

//--- tb/tb_lane_alarm_latch_bank.sv
// Self-checking testbench for the lane alarm latch bank
`timescale 1ns/1ns
module tb_lane_alarm_latch_bank;
   // ***************************************************
   // Signals
   // ***************************************************
   localparam int LANES = 4;                  // Fewer than the most, so absent lanes exist
   localparam logic [15:0] ONE = lane_alarm_pkg::LATCH_ONE_BASE;  // Word one, lane 0
   localparam logic [15:0] TWO = lane_alarm_pkg::LATCH_TWO_BASE;  // Word two, lane 0
   localparam logic [15:0] SEL = lane_alarm_pkg::RX_THR_SEL_ADDR; // Threshold select
   logic ref_clk;                             // Bench clock
   logic rst;                                 // Async reset
   logic clk_en;                              // Clock enable
   logic [15:0] reg_addr;                     // Register address
   logic [15:0] reg_wdata;                    // Write data
   logic reg_wr;                              // Write strobe
   logic reg_rd;                              // Read strobe
   logic [15:0] reg_rdata;                    // Read data
   logic rx_thr_sel;                          // Select bit seen at the port
   lane_alarm_pkg::latch_one_t [lane_alarm_pkg::LANE_MAX-1:0] live_one;
   lane_alarm_pkg::flag_group_t [lane_alarm_pkg::LANE_MAX-1:0] rx_power_alt;
   lane_alarm_pkg::latch_two_t [lane_alarm_pkg::LANE_MAX-1:0] live_two;
   int miscompares;                           // Mismatches seen
   int n_checks;                              // Comparisons made
   int cycles;                                // Timeout counter

   // Design under test
   lane_alarm_latch_bank #(.LANE_COUNT(LANES)) DUT (
      .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .live_one(live_one), .rx_power_alt(rx_power_alt), .live_two(live_two),
      .rx_thr_sel(rx_thr_sel)
   );

   // ***************************************************
   // Clock and timeout
   // ***************************************************
   // Free-running 125 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   // Cut a hang short well past the expected run length
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         miscompares++;
         summarize();
      end
   end

   // ***************************************************
   // Tasks
   // ***************************************************
   // Compare one value and report a difference
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One-cycle write strobe
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   // One-cycle read strobe, data checked in the following cycle only
   task automatic rd(input logic [15:0] a, input logic [15:0] exp);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      check(reg_rdata, exp);
   endtask

   // Live flags of one source asserted for exactly one cycle
   task automatic pulse(input int w, input int l, input logic [15:0] v);
      @(posedge ref_clk);
      if (w == 1)
         live_one[l] <= v;
      else if (w == 2)
         live_two[l] <= v;
      else
         rx_power_alt[l] <= v[3:0];
      @(posedge ref_clk);
      live_one[l] <= '0;
      live_two[l] <= '0;
      rx_power_alt[l] <= '0;
   endtask

   // Print the counts and the verdict, then stop
   task automatic summarize();
      $display("checks %0d, mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ***************************************************
   // Main sequence
   // ***************************************************
   initial begin
      rst = 1'b1;
      clk_en = 1'b1;
      reg_addr = '0;
      reg_wdata = '0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      live_one = '0;
      live_two = '0;
      rx_power_alt = '0;
      miscompares = 0;
      n_checks = 0;
      cycles = 0;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      // Reset values, every lane of both words
      for (int l = 0; l < LANES; l++) begin
         rd(ONE + 16'(l), 16'h0000);
         rd(TWO + 16'(l), 16'h0000);
      end
      rd(SEL, 16'h0000);
      // Each flag bit latches after its pulse ends, then clears on read
      for (int b = 0; b < 16; b++) begin
         pulse(1, b % LANES, 16'h0001 << b);
         rd(ONE + 16'(b % LANES), 16'h0001 << b);
         rd(ONE + 16'(b % LANES), 16'h0000);
         pulse(2, b % LANES, 16'h0001 << b);
         rd(TWO + 16'(b % LANES), 16'h0001 << b);
         rd(TWO + 16'(b % LANES), 16'h0000);
      end
      // Named fields land where the layout says
      @(posedge ref_clk);
      live_one[1].laser_temp.low_warning <= 1'b1;
      live_two[2].rx_laser_output.high_warning <= 1'b1;
      pulse(1, 0, 16'h8000);
      rd(ONE, 16'h8000);
      rd(ONE + 16'h0001, 16'h0020);
      rd(TWO + 16'h0002, 16'h0400);
      // Writes to a latch word change nothing
      pulse(1, 3, 16'ha5c3);
      wr(ONE + 16'h0003, 16'h0000);
      wr(TWO + 16'h0003, 16'hffff);
      rd(ONE + 16'h0003, 16'ha5c3);
      rd(TWO + 16'h0003, 16'h0000);
      #9;
      check(reg_rdata, 16'h0000);
      // Threshold select steers the receive power flags
      pulse(3, 0, 16'h000f);
      rd(ONE, 16'h0000);
      wr(SEL, 16'h0001);
      #1;
      check({15'h0000, rx_thr_sel}, 16'h0001);
      rd(SEL, 16'h0001);
      pulse(1, 0, 16'h0009);
      pulse(3, 0, 16'h000e);
      rd(ONE, 16'h000e);
      wr(SEL, 16'h0000);
      // Condition held across a read is not lost
      @(posedge ref_clk);
      live_two[1] <= 16'h8001;
      rd(TWO + 16'h0001, 16'h8001);
      rd(TWO + 16'h0001, 16'h8001);
      @(posedge ref_clk);
      live_two[1] <= '0;
      rd(TWO + 16'h0001, 16'h8001);
      rd(TWO + 16'h0001, 16'h0000);
      // Absent lanes and stray addresses read zero
      pulse(1, LANES, 16'hffff);
      rd(ONE + 16'(LANES), 16'h0000);
      rd(ONE + 16'h000f, 16'h0000);
      rd(16'hb1d0, 16'h0000);
      // Frozen clock enable takes no flags
      @(posedge ref_clk);
      clk_en <= 1'b0;
      pulse(2, 0, 16'h00ff);
      clk_en <= 1'b1;
      rd(TWO, 16'h0000);
      summarize();
   end
endmodule
